/* File: hdl/drr_pkg.sv */
// Constants and types shared by the range, reference and alarm register bank.
`default_nettype none
package drr_pkg;
    // ----------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_CH4_RANGE  = 6'h19;
    localparam logic [5:0] IDX_CH5_RANGE  = 6'h1A;
    localparam logic [5:0] IDX_REFERENCE  = 6'h1B;
    localparam logic [5:0] IDX_FAULT_CFG  = 6'h1C;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
    localparam logic [5:0] IDX_IRQ_CLEAR  = 6'h31;
    localparam logic [5:0] IDX_IRQ_ENABLE = 6'h32;
    localparam logic [5:0] IDX_FAULT_LIVE = 6'h33;

    // ----------------------------------------------------------------
    // Field positions.
    // ----------------------------------------------------------------
    localparam int POS_RANGE_SEL   = 0;
    localparam int POS_SCALE_LSB   = 2;
    localparam int POS_RES_SEL     = 2;
    localparam int POS_VREF_LSB    = 0;
    localparam int POS_OPEN_DRAIN  = 0;
    localparam int POS_TSD_EN      = 1;
    localparam int POS_CRC_EN      = 2;
    localparam int POS_MASK_LSB    = 3;
    localparam int POS_FLT_WARN    = 0;
    localparam int POS_FLT_OTEMP   = 1;
    localparam int POS_FLT_NEGMON  = 2;
    localparam int POS_FLT_RESIST  = 3;
    localparam int POS_FLT_CRC     = 4;

    // ----------------------------------------------------------------
    // Reset values.
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_RANGE     = 8'h00;
    localparam logic [7:0] RST_REFERENCE = 8'h00;
    localparam logic [7:0] RST_FAULT_CFG = 8'h06;
    localparam logic [4:0] RST_IRQ       = 5'h00;

    // ----------------------------------------------------------------
    // Timing.
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int CRC_PERIOD_NS = 40000;
    localparam logic [9:0] CRC_LAST = 10'(CRC_PERIOD_NS / CLK_PERIOD_NS - 1);

    // Range and reference settings driven towards the analog core.
    typedef struct packed {
        logic [5:0] fourth_chan_scale_factor;
        logic       fourth_chan_range_select;
        logic [5:0] fifth_chan_scale_factor;
        logic       fifth_chan_range_select;
        logic       ext_resistor_sel;
        logic [1:0] vref_sel;
    } drr_cfg_t;
endpackage
`default_nettype wire

/* File: hdl/drr_regs.sv */
// Register bank for channel 4/5 ranges, reference selection and fault alarm setup.
// What this block does
// RULE_01: Channel 4 range bit 0: 0 gives 45 mA, 1 gives 100 mA full scale.
// RULE_02: Channel 5 range bit 0 decodes the same 45 mA or 100 mA choice.
// RULE_03: Bits 7..2 of both range registers hold a six-bit scale factor, reset zero.
// RULE_04: Reference bit 2 picks internal (0) or external (1) current resistor.
// RULE_05: Reference bits 1..0 pick one of four voltage reference schemes.
// RULE_06: Alarm bit 7 masks the alarm for background register check errors.
// RULE_07: Alarm bit 6 masks the alarm for external resistor faults.
// RULE_08: Alarm bit 5 masks the alarm for negative monitor output voltage.
// RULE_09: Alarm bit 4 masks the alarm for over-temperature faults.
// RULE_10: Alarm bit 3 masks the alarm for over-temperature warnings.
// RULE_11: Alarm bit 2, reset one, enables a periodic CRC over the registers.
// RULE_12: Alarm bit 1, reset one, enables thermal shutdown on over-temperature.
// RULE_13: Alarm bit 0 makes the alarm pin open drain; zero keeps it driven.
// RULE_14: Alarm configuration register resets to 0x06.
// RULE_15: Channel 4 range register sits at index 0x19 and resets to zero.
// RULE_16: Reserved bits read zero and ignore writes.
// RULE_17: Alarm is active whenever any unmasked monitored fault is present.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module drr_regs
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [3:0]        fault_in,
    input  wire logic              alarm_n_in,
    output logic                   alarm_n_out,
    output logic                   alarm_n_oe,
    output logic                   thermal_shutdown,
    output logic                   crc_check_active,
    output logic                   irq,
    output drr_pkg::drr_cfg_t      cfg_out
);
    import drr_pkg::*;

    // ----------------------------------------------------------------
    // State and helpers
    // ----------------------------------------------------------------
    typedef struct packed {
        drr_cfg_t   cfg;
        logic [7:0] fault_cfg;
        logic [4:0] irq_status;
        logic [4:0] irq_enable;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] sync3;
        logic [3:0] flt;
        logic [2:0] pin_sync;
        logic       pin_lvl;
        logic [9:0] crc_cnt;
        logic [7:0] crc_ref;
        logic       crc_dirty;
        logic [31:0] rdata;
        logic       slverr;
        logic       ready;
        logic       alarm_n;
        logic       alarm_oe;
        logic       tsd;
        logic       irq;
    } drr_state_t;

    drr_state_t st;
    drr_state_t next_st;

    // Tells whether a byte address is word aligned and hits a mapped register index.
    function automatic logic is_mapped(input logic [7:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        is_mapped = (addr[1:0] == 2'h0) &&
                    (idx == IDX_CH4_RANGE || idx == IDX_CH5_RANGE ||
                     idx == IDX_REFERENCE || idx == IDX_FAULT_CFG ||
                     idx == IDX_IRQ_STATUS || idx == IDX_IRQ_CLEAR ||
                     idx == IDX_IRQ_ENABLE || idx == IDX_FAULT_LIVE);
    endfunction

    // CRC-8 with polynomial x^8+x^2+x+1 over one 32-bit word.
    function automatic logic [7:0] crc8(input logic [31:0] data);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--)
        begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ data[i]) ? 8'h07 : 8'h00);
        end
        crc8 = c;
    endfunction

    logic        setup_ph;
    logic        wr_acc;
    logic [5:0]  acc_idx;
    logic [31:0] crc_word;
    logic [31:0] rd_word;
    logic        crc_tick;
    logic        crc_bad;
    logic [4:0]  events;
    logic [4:0]  clr_bits;
    logic [4:0]  alarm_src;
    logic        alarm_act;
    logic [3:0]  agree;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Bus phases, register decode, fault filtering and alarm drive.
    always_comb
    begin
        next_st  = st;
        setup_ph = psel && !penable;
        wr_acc   = psel && penable && pwrite && !st.slverr;
        acc_idx  = paddr[7:2];
        crc_word = {7'h00, st.cfg, st.fault_cfg};
        clr_bits = 5'h00;

        // Read mux; reserved bits are left at zero.
        rd_word = 32'h0000_0000;
        case (acc_idx)
            IDX_CH4_RANGE:                                                   // RULE_15
            begin
                rd_word[7:2] = st.cfg.fourth_chan_scale_factor;
                rd_word[0]   = st.cfg.fourth_chan_range_select;              // RULE_16
            end
            IDX_CH5_RANGE:
            begin
                rd_word[7:2] = st.cfg.fifth_chan_scale_factor;
                rd_word[0]   = st.cfg.fifth_chan_range_select;
            end
            IDX_REFERENCE:
            begin
                rd_word[2]   = st.cfg.ext_resistor_sel;
                rd_word[1:0] = st.cfg.vref_sel;
            end
            IDX_FAULT_CFG:  rd_word[7:0] = st.fault_cfg;
            IDX_IRQ_STATUS: rd_word[4:0] = st.irq_status;
            IDX_IRQ_ENABLE: rd_word[4:0] = st.irq_enable;
            IDX_FAULT_LIVE: rd_word[4:0] = {st.pin_lvl, st.flt};
            default:        rd_word = 32'h0000_0000;
        endcase

        // Read data and error are prepared in setup so the access phase needs no wait.
        next_st.ready = 1'b1;
        if (setup_ph)
        begin
            next_st.slverr = !is_mapped(paddr);
            next_st.rdata  = (is_mapped(paddr) && !pwrite) ? rd_word : 32'h0000_0000;
        end

        // Register writes take effect at the access edge.
        if (wr_acc)
        begin
            case (acc_idx)
                IDX_CH4_RANGE:
                begin
                    next_st.cfg.fourth_chan_scale_factor = pwdata[POS_SCALE_LSB +: 6];  // RULE_03
                    next_st.cfg.fourth_chan_range_select = pwdata[POS_RANGE_SEL];       // RULE_01
                end
                IDX_CH5_RANGE:
                begin
                    next_st.cfg.fifth_chan_scale_factor = pwdata[POS_SCALE_LSB +: 6];   // RULE_03
                    next_st.cfg.fifth_chan_range_select = pwdata[POS_RANGE_SEL];        // RULE_02
                end
                IDX_REFERENCE:
                begin
                    next_st.cfg.ext_resistor_sel = pwdata[POS_RES_SEL];                 // RULE_04
                    next_st.cfg.vref_sel         = pwdata[POS_VREF_LSB +: 2];           // RULE_05
                end
                IDX_FAULT_CFG:  next_st.fault_cfg  = pwdata[7:0];
                IDX_IRQ_CLEAR:  clr_bits           = pwdata[4:0];
                IDX_IRQ_ENABLE: next_st.irq_enable = pwdata[4:0];
                default:        next_st.fault_cfg  = st.fault_cfg;
            endcase
        end

        // Fault inputs pass three stages; a change counts once stages two and three agree.
        next_st.sync1    = fault_in;
        next_st.sync2    = st.sync1;
        next_st.sync3    = st.sync2;
        agree            = ~(st.sync2 ^ st.sync3);
        next_st.flt      = (agree & st.sync3) | (~agree & st.flt);
        next_st.pin_sync = {st.pin_sync[1:0], alarm_n_in};
        if (st.pin_sync[1] == st.pin_sync[2])
        begin
            next_st.pin_lvl = st.pin_sync[2];
        end

        // Periodic register check; a write resynchronises the reference value.
        crc_tick = 1'b0;
        crc_bad  = 1'b0;
        if (st.fault_cfg[POS_CRC_EN])                                        // RULE_11
        begin
            crc_tick        = (st.crc_cnt == CRC_LAST);
            next_st.crc_cnt = crc_tick ? 10'h000 : st.crc_cnt + 10'h001;
            if (crc_tick && st.crc_dirty)
            begin
                next_st.crc_ref = crc8(crc_word);
            end
            crc_bad = crc_tick && !st.crc_dirty && (crc8(crc_word) != st.crc_ref);
            next_st.crc_dirty = wr_acc || (st.crc_dirty && !crc_tick);
        end
        else
        begin
            next_st.crc_cnt   = 10'h000;
            next_st.crc_dirty = 1'b1;
        end

        // Sticky status; a new event wins over a clear in the same cycle.
        events             = {crc_bad, next_st.flt & ~st.flt};
        next_st.irq_status = (st.irq_status & ~clr_bits) | events;
        next_st.irq        = |(st.irq_status & st.irq_enable);

        // Alarm sources masked by bits 7..3 of the alarm configuration.
        alarm_src = {st.irq_status[POS_FLT_CRC], st.flt} & ~st.fault_cfg[POS_MASK_LSB +: 5];  // RULE_06 RULE_07
        alarm_act = |alarm_src;                                              // RULE_08 RULE_09 RULE_10 RULE_17

        // Active-low pin: open drain only pulls low, push-pull always drives.
        if (st.fault_cfg[POS_OPEN_DRAIN])                                    // RULE_13
        begin
            next_st.alarm_n  = 1'b0;
            next_st.alarm_oe = alarm_act;
        end
        else
        begin
            next_st.alarm_n  = !alarm_act;
            next_st.alarm_oe = 1'b1;
        end

        // Thermal shutdown follows the filtered over-temperature fault when enabled.
        next_st.tsd = st.fault_cfg[POS_TSD_EN] && st.flt[POS_FLT_OTEMP];     // RULE_12
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // All state resets to constants, including the configuration defaults.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st            <= '0;
            st.cfg        <= drr_cfg_t'({RST_RANGE[7:2], RST_RANGE[POS_RANGE_SEL],
                                         RST_RANGE[7:2], RST_RANGE[POS_RANGE_SEL],
                                         RST_REFERENCE[2:0]});
            st.fault_cfg  <= RST_FAULT_CFG;                                  // RULE_14
            st.irq_status <= RST_IRQ;
            st.irq_enable <= RST_IRQ;
            st.crc_dirty  <= 1'b1;
            st.ready      <= 1'b1;
            st.alarm_n    <= 1'b1;
            st.alarm_oe   <= 1'b1;
            st.pin_sync   <= 3'h7;
            st.pin_lvl    <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Every output is a field of the state register.
    assign prdata           = st.rdata;
    assign pready           = st.ready;
    assign pslverr          = st.slverr;
    assign alarm_n_out      = st.alarm_n;
    assign alarm_n_oe       = st.alarm_oe;
    assign thermal_shutdown = st.tsd;
    assign crc_check_active = st.fault_cfg[POS_CRC_EN];
    assign irq              = st.irq;
    assign cfg_out          = st.cfg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Marks whether software has written anything since reset.
    logic seen_wr;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seen_wr <= 1'b0;
        end
        else if (wr_acc)
        begin
            seen_wr <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A range write reaches the channel outputs one edge later.
    AST_CH4_RANGE: assert property (wr_acc && paddr[7:2] == IDX_CH4_RANGE |=> // RULE_01 RULE_03
        cfg_out.fourth_chan_range_select == $past(pwdata[0]) &&
        cfg_out.fourth_chan_scale_factor == $past(pwdata[7:2]))
        else $error("Channel 4 range write not applied.");

    AST_CH5_RANGE: assert property (wr_acc && paddr[7:2] == IDX_CH5_RANGE |=> // RULE_02
        cfg_out.fifth_chan_range_select == $past(pwdata[0]) &&
        cfg_out.fifth_chan_scale_factor == $past(pwdata[7:2]))
        else $error("Channel 5 range write not applied.");

    AST_REFERENCE: assert property (wr_acc && paddr[7:2] == IDX_REFERENCE |=> // RULE_04 RULE_05
        cfg_out.ext_resistor_sel == $past(pwdata[2]) && cfg_out.vref_sel == $past(pwdata[1:0]))
        else $error("Reference write not applied.");

    AST_RESERVED: assert property (psel && !penable && !pwrite && paddr == {IDX_CH4_RANGE, 2'h0} // RULE_16
        |=> prdata[31:8] == 24'h0 && prdata[1] == 1'b0)
        else $error("Reserved bits of range register read nonzero.");

    AST_DEFAULTS: assert property (!seen_wr |-> st.fault_cfg == 8'h06 && cfg_out == '0) // RULE_14 RULE_15
        else $error("Register defaults lost before any write.");

    AST_ALL_MASKED: assert property ((st.fault_cfg[7:3] == 5'h1F) [*2] |-> // RULE_06 RULE_07 RULE_08 RULE_09 RULE_10
        (alarm_n_out == 1'b1 || !alarm_n_oe))
        else $error("Alarm active although every source is masked.");

    AST_ALARM_ON: assert property ((st.flt[0] && !st.fault_cfg[3] && !st.fault_cfg[0]) [*2] |-> // RULE_17
        alarm_n_out == 1'b0 && alarm_n_oe)
        else $error("Unmasked warning did not drive the alarm low.");

    AST_OPEN_DRAIN: assert property ($past(st.fault_cfg[0]) |-> alarm_n_out == 1'b0) // RULE_13
        else $error("Open-drain alarm drove a high level.");

    AST_TSD: assert property ((fault_in[1] && st.fault_cfg[1]) [*6] |-> thermal_shutdown) // RULE_12
        else $error("Thermal shutdown missing after over-temperature.");

    AST_CRC_OFF: assert property (!st.fault_cfg[2] |=> st.crc_cnt == 10'h000 && !$rose(st.irq_status[4])) // RULE_11
        else $error("Register check ran while disabled.");

    AST_PREADY: assert property (psel && !penable |=> pready)
        else $error("Access phase not answered at once.");

    // A misaligned address is answered with an error in its access phase.
    AST_MISALIGNED: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("Misaligned access not refused.");

    // The interrupt rises one edge after an enabled status bit is set.
    AST_IRQ_SET: assert property ((st.irq_status & st.irq_enable) != 5'h00 |=> irq)
        else $error("Interrupt missing for an enabled status bit.");

    // The interrupt falls one edge after no enabled status bit remains.
    AST_IRQ_CLR: assert property ((st.irq_status & st.irq_enable) == 5'h00 |=> !irq)
        else $error("Interrupt high with no enabled status bit.");

    // A new event sets its status bit even when a clear arrives in the same cycle.
    AST_SET_WINS: assert property (events != 5'h00 |=> (st.irq_status & $past(events)) == $past(events))
        else $error("Status event lost against a clear.");

    // A driven alarm pin keeps its output enable on.
    AST_PUSH_PULL: assert property (!$past(st.fault_cfg[POS_OPEN_DRAIN]) |-> alarm_n_oe) // RULE_13
        else $error("Driven alarm pin released its output.");

    // With shutdown disabled the shutdown output stays low.
    AST_TSD_OFF: assert property (!st.fault_cfg[POS_TSD_EN] |=> !thermal_shutdown) // RULE_12
        else $error("Thermal shutdown while disabled.");

    // Quiet fault inputs leave the filtered faults clear after the three stages.
    AST_FLT_QUIET: assert property ((fault_in == 4'h0) [*5] |-> st.flt == 4'h0)
        else $error("Filtered fault set without an input fault.");

    COV_WRITE_ALARM: cover property (wr_acc && paddr[7:2] == IDX_FAULT_CFG);
    COV_ALARM_OD: cover property (st.fault_cfg[0] && alarm_n_oe);
    COV_TSD: cover property ($rose(thermal_shutdown));
    COV_IRQ: cover property ($rose(irq));
    COV_SLVERR: cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

/* File: dv/test_dac_range_ref_alarm_config_regs.sv */
// Self-checking testbench for the range, reference and alarm register bank.
`timescale 1ns/1ps
`default_nettype none
module test_dac_range_ref_alarm_config_regs;
    import drr_pkg::*;

    // ------------------------------------------------------------
    // Signals, table rows and counters.
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] idx;
        logic [7:0] wdata;
        logic [7:0] rdata;
    } drr_row_t;

    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [3:0]        fault_in;
    logic              alarm_n_in;
    logic              alarm_n_out;
    logic              alarm_n_oe;
    logic              thermal_shutdown;
    logic              crc_check_active;
    logic              irq;
    drr_cfg_t          cfg_out;
    logic [31:0]       rdv;
    logic              last_err;
    logic [7:0]        r4;
    logic [7:0]        r5;
    logic [7:0]        rf;
    int                fails;
    int                n_checks;
    int                cycles;
    drr_row_t          rows [12];

    // The alarm line is pulled up whenever nobody drives it.
    assign alarm_n_in = alarm_n_oe ? alarm_n_out : 1'b1;

    drr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_in(fault_in), .alarm_n_in(alarm_n_in), .alarm_n_out(alarm_n_out),
        .alarm_n_oe(alarm_n_oe), .thermal_shutdown(thermal_shutdown),
        .crc_check_active(crc_check_active), .irq(irq), .cfg_out(cfg_out));

    // Clock at 25 MHz.
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------
    // Compares one seen value with its expected value.
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One APB transfer: setup, then access until pready is seen high.
    task xfer(input logic [7:0] addr, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= addr;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] dummy;
        xfer({idx, 2'b00}, 1'b1, d, dummy);
    endtask

    task rd(input logic [5:0] idx, output logic [31:0] d);
        xfer({idx, 2'b00}, 1'b0, 32'h0, d);
    endtask

    // Raises or drops faults and lets the filter and alarm path settle.
    task set_fault(input logic [3:0] f);
        @(posedge pclk);
        fault_in <= f;
        repeat (10) @(posedge pclk);
    endtask

    // Cuts a hung run short.
    initial
    begin
        cycles = 0;
        forever
        begin
            @(posedge pclk);
            cycles++;
            if (cycles > 20000)
            begin
                fails++;
                complete_run();
            end
        end
    end

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fault_in = 4'h0;
        fails = 0;
        n_checks = 0;
        rows = '{'{IDX_CH4_RANGE, 8'hFF, 8'hFD}, '{IDX_CH4_RANGE, 8'hA4, 8'hA4},
                 '{IDX_CH5_RANGE, 8'hFE, 8'hFC}, '{IDX_CH5_RANGE, 8'h03, 8'h01},
                 '{IDX_REFERENCE, 8'hFF, 8'h07}, '{IDX_REFERENCE, 8'h00, 8'h00},
                 '{IDX_REFERENCE, 8'h01, 8'h01}, '{IDX_REFERENCE, 8'h02, 8'h02},
                 '{IDX_REFERENCE, 8'hFB, 8'h03}, '{IDX_FAULT_CFG, 8'hFF, 8'hFF},
                 '{IDX_FAULT_CFG, 8'h06, 8'h06}, '{IDX_CH4_RANGE, 8'h01, 8'h01}};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values at the pins and in the registers.
        check(32'(cfg_out), 32'h0);
        check({28'h0, pready, crc_check_active, alarm_n_out, alarm_n_oe}, 32'hF);
        check({30'h0, irq, thermal_shutdown}, 32'h0);
        rd(IDX_CH4_RANGE, rdv); check(rdv, 32'(RST_RANGE));
        rd(IDX_CH5_RANGE, rdv); check(rdv, 32'h00);
        rd(IDX_REFERENCE, rdv); check(rdv, 32'h00);
        rd(IDX_FAULT_CFG, rdv); check(rdv, 32'h06);
        rd(IDX_IRQ_ENABLE, rdv); check(rdv, 32'h0);
        // Table of writes, readbacks and decoded settings.
        r4 = 8'h00; r5 = 8'h00; rf = 8'h00;
        foreach (rows[i])
        begin
            wr(rows[i].idx, {24'hFFFFFF, rows[i].wdata});
            rd(rows[i].idx, rdv);
            check(rdv, {24'h0, rows[i].rdata});
            if (rows[i].idx == IDX_CH4_RANGE) r4 = rows[i].rdata;
            if (rows[i].idx == IDX_CH5_RANGE) r5 = rows[i].rdata;
            if (rows[i].idx == IDX_REFERENCE) rf = rows[i].rdata;
            check(32'(cfg_out), 32'({r4[7:2], r4[0], r5[7:2], r5[0], rf[2], rf[1:0]}));
        end
        // Each fault input raises the alarm and its status bit; its own mask silences it.
        for (int i = 0; i < 4; i++)
        begin
            set_fault(4'(1 << i));
            check(32'(alarm_n_out), 32'h0);
            check(32'(thermal_shutdown), 32'(i == 1));
            rd(IDX_IRQ_STATUS, rdv); check(rdv, 32'(1 << i));
            wr(IDX_FAULT_CFG, 32'h06 | 32'(1 << (3 + i)));
            repeat (3) @(posedge pclk);
            check(32'(alarm_n_out), 32'h1);
            wr(IDX_FAULT_CFG, 32'h06);
            set_fault(4'h0);
            wr(IDX_IRQ_CLEAR, 32'h1F);
            rd(IDX_IRQ_CLEAR, rdv); check(rdv, 32'h0);
        end
        // Interrupt: enabled status drives irq, clearing drops it, status is read only.
        wr(IDX_IRQ_ENABLE, 32'h01);
        wr(IDX_IRQ_STATUS, 32'h1F);
        set_fault(4'h1);
        check(32'(irq), 32'h1);
        wr(IDX_IRQ_ENABLE, 32'h00);
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h0);
        wr(IDX_IRQ_ENABLE, 32'h01);
        wr(IDX_IRQ_CLEAR, 32'h01);
        repeat (2) @(posedge pclk);
        check(32'(irq), 32'h0);
        rd(IDX_IRQ_STATUS, rdv); check(rdv, 32'h0);
        set_fault(4'h0);
        // Open-drain alarm pin: drives low while active, released otherwise.
        wr(IDX_FAULT_CFG, 32'h07);
        set_fault(4'h8);
        check({30'h0, alarm_n_out, alarm_n_oe}, 32'h1);
        rd(IDX_FAULT_LIVE, rdv); check(rdv, 32'h08);
        set_fault(4'h0);
        check(32'(alarm_n_oe), 32'h0);
        rd(IDX_FAULT_LIVE, rdv); check(rdv, 32'h10);
        // Periodic check off, thermal shutdown off.
        wr(IDX_FAULT_CFG, 32'h00);
        set_fault(4'h2);
        check(32'(crc_check_active), 32'h0);
        check({30'h0, thermal_shutdown, alarm_n_out}, 32'h0);
        set_fault(4'h0);
        // Unmapped and misaligned accesses are refused.
        xfer(8'h80, 1'b1, 32'hFF, rdv); check(32'(last_err), 32'h1);
        rd(6'h20, rdv); check({rdv[30:0], last_err}, 32'h1);
        xfer(8'h65, 1'b1, 32'hFF, rdv); check(32'(last_err), 32'h1);
        rd(IDX_CH4_RANGE, rdv); check(rdv, 32'h01);
        // Reset in mid-run restores the reset values.
        wr(IDX_CH4_RANGE, 32'hA5);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(IDX_CH4_RANGE, rdv); check(rdv, 32'h00);
        rd(IDX_FAULT_CFG, rdv); check(rdv, 32'(RST_FAULT_CFG));
        complete_run();
    end
endmodule
`default_nettype wire
